/* rtl/servo_setup.v */
// resolution, phase output, home setting and backup key logic
`timescale 1ns/1ns
`include "servo_setup_defs.vh"

module servo_setup
#(
  parameter HOLD_CYC    = `HOLD_CYC,
  parameter WINDOW_CYC  = `WINDOW_CYC,
  parameter CONFIRM_CYC = `CONFIRM_CYC,
  parameter BLINK_CYC   = `BLINK_CYC,
  parameter MOTOR_BASE  = `MOTOR_BASE
)
(
  input  wire        mclk,
  input  wire        resetn,
  input  wire        power_up,
  input  wire        config_exec,
  input  wire        param_wr,
  input  wire [15:0] param_id,
  input  wire [31:0] param_wdata,
  input  wire [15:0] sensor_gear_a,
  input  wire [15:0] sensor_gear_b,
  input  wire        motor_step,
  input  wire        motor_dir,
  input  wire        home_switch,
  input  wire        nv_home_valid,
  output reg  [13:0] resolution,
  output reg         gear_error_info,
  output reg         gear_error_alarm,
  output reg         preset_again,
  output reg  [31:0] present_position,
  output reg         phase_a_pulse_output,
  output reg         phase_b_pulse_output,
  output reg         led_red,
  output reg         led_green,
  output reg         home_write,
  output reg  [23:0] home_position,
  output reg         home_valid,
  output reg         backup_restore,
  output reg         backup_store,
  output reg         backup_reject
);

  // divider states
  localparam D_IDLE = 3'b001;
  localparam D_RES  = 3'b010;
  localparam D_POS  = 3'b100;
  // home sequence states
  localparam H_IDLE    = 5'b00001;
  localparam H_HOLD    = 5'b00010;
  localparam H_RELEASE = 5'b00100;
  localparam H_PRESS   = 5'b01000;
  localparam H_CONFIRM = 5'b10000;

  reg [31:0] access_key;
  reg [31:0] write_key;
  reg        mech_source;
  reg        mech_active;
  reg [15:0] gear_a;
  reg [15:0] gear_b;
  reg [31:0] preset_pos;
  reg        res_dirty;
  reg [2:0]  div_state;
  reg [39:0] div_num;
  reg [16:0] div_rem;
  reg [15:0] div_den;
  reg [5:0]  div_cnt;
  reg [23:0] motor_count;
  reg [15:0] phase_acc;
  reg [1:0]  quad;
  reg [4:0]  home_state;
  reg [31:0] home_cnt;
  reg [31:0] blink_cnt;
  reg        blink;
  reg        nv_seen;

  wire [15:0] eff_gear_a = mech_active ? gear_a : sensor_gear_a;
  wire [15:0] eff_gear_b = mech_active ? gear_b : sensor_gear_b;
  wire        wr_ok      = param_wr && (param_wdata[31:16] == 16'h0000)
                           && (param_wdata[15:0] != 16'h0000);
  wire        access_ok  = (access_key == `ACCESS_KEY_CODE);
  wire        write_ok   = (write_key == `WRITE_KEY_CODE);
  wire [16:0] rem_shift  = {div_rem[15:0], div_num[39]};
  wire        rem_ge     = (rem_shift >= {1'b0, div_den});
  wire [39:0] div_q      = {div_num[38:0], rem_ge};
  wire [15:0] res_ext    = {2'b00, resolution};
  wire [15:0] base       = MOTOR_BASE[15:0];

  // quadrature count to phase pins: gray sequence
  function [1:0] quad_pins;
    input [1:0] q;
    begin
      quad_pins = {q[1], q[1] ^ q[0]};
    end
  endfunction

  // parameter port: keys, source, gears, preset, commands
  always @(posedge mclk)
  begin
    backup_restore <= 1'b0;
    backup_store   <= 1'b0;
    backup_reject  <= 1'b0;
    if (!resetn)
    begin
      access_key  <= `KEY_RESET;
      write_key   <= `KEY_RESET;
      mech_source <= `SRC_SENSOR;
      mech_active <= `SRC_SENSOR;
      gear_a      <= `GEAR_RESET;
      gear_b      <= `GEAR_RESET;
      preset_pos  <= 32'h00000000;
    end
    else
    begin
      if (power_up)
        mech_active <= mech_source;
      if (param_wr)
      begin
        case (param_id)
          `ID_ACCESS_KEY:  access_key <= param_wdata;
          `ID_WRITE_KEY:   write_key <= param_wdata;
          `ID_MECH_SOURCE: mech_source <= param_wdata[0];
          `ID_PRESET_POS:  preset_pos <= param_wdata;
          `ID_GEAR_A:
            if (wr_ok && mech_source == `SRC_MANUAL)
              gear_a <= param_wdata[15:0];
          `ID_GEAR_B:
            if (wr_ok && mech_source == `SRC_MANUAL)
              gear_b <= param_wdata[15:0];
          `ID_RESTORE_CMD:
            if (access_ok)
              backup_restore <= 1'b1;
            else
              backup_reject <= 1'b1;
          `ID_STORE_CMD:
            if (access_ok && write_ok)
              backup_store <= 1'b1;
            else
              backup_reject <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // shared divider: resolution, then position rescale
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      div_state        <= D_IDLE;
      div_num          <= 40'h0000000000;
      div_rem          <= 17'h00000;
      div_den          <= 16'h0001;
      div_cnt          <= 6'h00;
      res_dirty        <= 1'b0;
      resolution       <= `RES_RESET;
      gear_error_info  <= 1'b0;
      gear_error_alarm <= 1'b0;
      preset_again     <= 1'b0;
    end
    else
    begin
      if (param_wr && (param_id == `ID_GEAR_A || param_id == `ID_GEAR_B))
        res_dirty <= 1'b1;
      if (param_wr && param_id == `ID_PRESET_POS)
        preset_again <= 1'b0;
      if (power_up || config_exec)
      begin
        res_dirty <= 1'b1;
        if (gear_error_info)
          gear_error_alarm <= 1'b1;
      end
      case (div_state)
        D_IDLE:
          if (res_dirty && !(power_up || config_exec || param_wr))
          begin
            res_dirty <= 1'b0;
            div_num   <= {14'h0000, `RES_SCALE} * {24'h000000, eff_gear_b};
            div_den   <= eff_gear_a;
            div_rem   <= 17'h00000;
            div_cnt   <= 6'h00;
            div_state <= D_RES;
          end
        D_RES, D_POS:
        begin
          div_rem <= rem_ge ? rem_shift - {1'b0, div_den} : rem_shift;
          div_num <= {div_num[38:0], rem_ge};
          div_cnt <= div_cnt + 6'h01;
          if (div_cnt == 6'h27)
          begin
            div_state <= D_IDLE;
            if (div_state == D_RES)
            begin
              if (div_q < `RES_MIN || div_q > `RES_MAX)
                gear_error_info <= 1'b1;
              else
              begin
                gear_error_info <= 1'b0;
                // only a real change of resolution counts
                if ({26'h0000000, resolution} != div_q)
                begin
                  resolution <= div_q[13:0];
                  if (preset_pos != 32'h00000000)
                    preset_again <= 1'b1;
                  else
                  begin
                    div_num   <= {16'h0000, motor_count} *
                                 {26'h0000000, div_q[13:0]};
                    div_den   <= base;
                    div_rem   <= 17'h00000;
                    div_cnt   <= 6'h00;
                    div_state <= D_POS;
                  end
                end
              end
            end
          end
        end
        default: div_state <= D_IDLE;
      endcase
    end
  end

  // motor motion to scaled quadrature and present position
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      motor_count          <= 24'h000000;
      phase_acc            <= 16'h0000;
      quad                 <= 2'b00;
      present_position     <= 32'h00000000;
      phase_a_pulse_output <= 1'b0;
      phase_b_pulse_output <= 1'b0;
    end
    else
    begin
      if (div_state == D_POS && div_cnt == 6'h27)
        present_position <= {div_num[30:0], rem_ge};
      else if (motor_step && !motor_dir)
      begin
        motor_count <= motor_count + 24'h000001;
        if (phase_acc + res_ext >= base)
        begin
          phase_acc        <= phase_acc + res_ext - base;
          quad             <= quad + 2'b01;
          present_position <= present_position + 32'h00000001;
        end
        else
          phase_acc <= phase_acc + res_ext;
      end
      else if (motor_step && motor_dir)
      begin
        motor_count <= motor_count - 24'h000001;
        if (phase_acc < res_ext)
        begin
          phase_acc        <= phase_acc + base - res_ext;
          quad             <= quad - 2'b01;
          present_position <= present_position - 32'h00000001;
        end
        else
          phase_acc <= phase_acc - res_ext;
      end
      {phase_a_pulse_output, phase_b_pulse_output} <= quad_pins(quad);
    end
  end

  // home switch sequence, indicator and home store
  always @(posedge mclk)
  begin
    home_write <= 1'b0;
    if (!resetn)
    begin
      home_state    <= H_IDLE;
      home_cnt      <= 32'h00000000;
      blink_cnt     <= 32'h00000000;
      blink         <= 1'b0;
      led_red       <= 1'b0;
      led_green     <= 1'b1;
      home_position <= 24'h000000;
      home_valid    <= 1'b0;
      nv_seen       <= 1'b0;
    end
    else
    begin
      if (!nv_seen)
      begin
        nv_seen    <= 1'b1;
        home_valid <= nv_home_valid;
      end
      home_cnt <= home_cnt + 32'h00000001;
      if (blink_cnt >= BLINK_CYC - 1)
      begin
        blink_cnt <= 32'h00000000;
        blink     <= ~blink;
      end
      else
        blink_cnt <= blink_cnt + 32'h00000001;
      case (home_state)
        H_IDLE:
        begin
          led_red   <= 1'b0;
          led_green <= 1'b1;
          home_cnt  <= 32'h00000000;
          if (home_switch)
            home_state <= H_HOLD;
        end
        H_HOLD:
          if (!home_switch)
            home_state <= H_IDLE;
          else if (home_cnt >= HOLD_CYC - 1)
          begin
            home_state <= H_RELEASE;
            home_cnt   <= 32'h00000000;
            blink_cnt  <= 32'h00000000;
            blink      <= 1'b1;
          end
        H_RELEASE, H_PRESS:
        begin
          led_red   <= blink;
          led_green <= blink;
          if (home_cnt >= WINDOW_CYC - 1)
            home_state <= H_IDLE;
          else if (home_state == H_RELEASE && !home_switch)
          begin
            home_state <= H_PRESS;
            home_cnt   <= 32'h00000000;
          end
          else if (home_state == H_PRESS && home_switch)
          begin
            home_state <= H_CONFIRM;
            home_cnt   <= 32'h00000000;
          end
        end
        H_CONFIRM:
        begin
          led_red   <= 1'b1;
          led_green <= 1'b1;
          if (home_cnt >= CONFIRM_CYC - 1)
          begin
            home_state    <= H_IDLE;
            home_write    <= 1'b1;
            home_position <= motor_count;
            home_valid    <= 1'b1;
          end
        end
        default: home_state <= H_IDLE;
      endcase
    end
  end

endmodule // servo_setup

/* pkg/servo_setup_defs.vh */
// constants for the servo setup, home and backup logic
`ifndef SERVO_SETUP_DEFS_VH
`define SERVO_SETUP_DEFS_VH
// parameter identifiers on the parameter port
`define ID_ACCESS_KEY    16'h0020
`define ID_WRITE_KEY     16'h0021
`define ID_RESTORE_CMD   16'h00CB
`define ID_STORE_CMD     16'h00CC
`define ID_MECH_SOURCE   16'h0100
`define ID_GEAR_A        16'h0101
`define ID_GEAR_B        16'h0102
`define ID_PRESET_POS    16'h0103
// key codes and reset values
`define ACCESS_KEY_CODE  32'h01391955
`define WRITE_KEY_CODE   32'h75DB9C97
`define KEY_RESET        32'h00000000
`define GEAR_RESET       16'h0001
`define RES_SCALE        26'h00003E8
`define RES_MIN          40'h0000000064
`define RES_MAX          40'h0000002710
`define RES_RESET        14'h03E8
`define SRC_SENSOR       1'b0
`define SRC_MANUAL       1'b1
// timing: _MS figures in ms, clock in Hz, BLINK_CYC in cycles
`define CLK_HZ           100000000
`define HOLD_MS          1000
`define WINDOW_MS        3000
`define CONFIRM_MS       100
`define HOLD_CYC         (`HOLD_MS * (`CLK_HZ / 1000))
`define WINDOW_CYC       (`WINDOW_MS * (`CLK_HZ / 1000))
`define CONFIRM_CYC      (`CONFIRM_MS * (`CLK_HZ / 1000))
`define BLINK_CYC        25000000
`define MOTOR_BASE       10000
`endif

/* tb/servo_setup_chk.sv */
// port checker for the servo setup block
`timescale 1ns/1ns
`include "servo_setup_defs.vh"
module servo_setup_chk
(
  input wire        mclk,
  input wire        resetn,
  input wire        power_up,
  input wire        config_exec,
  input wire        param_wr,
  input wire [15:0] param_id,
  input wire [13:0] resolution,
  input wire        gear_error_info,
  input wire        gear_error_alarm,
  input wire        phase_a_pulse_output,
  input wire        phase_b_pulse_output,
  input wire        led_red,
  input wire        led_green,
  input wire        home_write,
  input wire        home_valid,
  input wire        backup_restore,
  input wire        backup_store,
  input wire        backup_reject
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // command writes decoded from the parameter port
  wire rst_wr = param_wr && param_id == `ID_RESTORE_CMD;
  wire sto_wr = param_wr && param_id == `ID_STORE_CMD;
  reset_values_a: assert property (disable iff (1'b0) !resetn |=>
    resolution == 14'h03E8 && led_green && !gear_error_alarm)
    else $error("reset values wrong");
  cmd_answer_a: assert property ((rst_wr || sto_wr) |=>
    $onehot({backup_restore, backup_store, backup_reject}))
    else $error("command without single answer");
  restore_cause_a: assert property (backup_restore |-> $past(rst_wr))
    else $error("restore without command");
  store_cause_a: assert property (backup_store |-> $past(sto_wr))
    else $error("store without command");
  alarm_escalate_a: assert property ((power_up || config_exec) &&
    gear_error_info |=> gear_error_alarm)
    else $error("alarm not raised");
  alarm_sticky_a: assert property (gear_error_alarm |=> gear_error_alarm)
    else $error("alarm dropped");
  res_range_a: assert property (resolution >= 14'h0064 &&
    resolution <= 14'h2710)
    else $error("resolution out of range");
  phase_gray_a: assert property ($countones({phase_a_pulse_output,
    phase_b_pulse_output} ^ {$past(phase_a_pulse_output),
    $past(phase_b_pulse_output)}) <= 1)
    else $error("both phases changed");
  red_with_green_a: assert property (led_red |-> led_green)
    else $error("red without green");
  home_valid_a: assert property (home_write |=> home_valid)
    else $error("home not valid after store");
  cover property (backup_restore);
  cover property (backup_store);
  cover property (home_write);
  cover property (gear_error_alarm);
endmodule // servo_setup_chk

bind servo_setup servo_setup_chk chk (.*);

/* tb/switch_operator.sv */
// operator model pressing the home-set switch
`timescale 1ns/1ns
module switch_operator
(
  input  wire       mclk,
  input  wire       go,
  input  wire [7:0] hold_cyc,
  input  wire [7:0] gap_cyc,
  input  wire       again,
  output reg        home_switch,
  output reg        busy
);
  initial
  begin
    home_switch = 1'b0;
    busy = 1'b0;
  end
  // long press, release, optional second press
  always @(posedge go)
  begin
    busy <= 1'b1;
    home_switch <= 1'b1;
    repeat (hold_cyc) @(posedge mclk);
    home_switch <= 1'b0; // release after hold_cyc cycles
    if (again)
    begin
      repeat (gap_cyc) @(posedge mclk);
      home_switch <= 1'b1; // second press inside the window
      repeat (10) @(posedge mclk);
      home_switch <= 1'b0;
    end
    busy <= 1'b0;
  end
endmodule // switch_operator

/* tb/tb.sv */
// self-checking bench for the servo setup block
`timescale 1ns/1ns
`include "servo_setup_defs.vh"
`define check(got, exp, msg) \
  begin \
    n_compared = n_compared + 1; \
    if ((got) !== (exp)) \
    begin \
      failures = failures + 1; \
      $display("ERROR %0t %s", $time, msg); \
    end \
  end
module tb;
  reg         mclk, resetn, power_up, config_exec, param_wr, motor_step;
  reg         motor_dir, nvh;
  reg  [15:0] sga, sgb;
  wire [31:0] pos;
  wire [23:0] hpos;
  reg  [15:0] param_id;
  reg  [31:0] param_wdata, akey, wkey;
  reg  [7:0]  hold, gap;
  reg         again, go;
  wire [13:0] resolution;
  wire        info, alarm, pa, ph_a, ph_b, led_red, led_green;
  wire        home_write, home_valid, b_rst, b_sto, b_rej, sw, busy;
  integer     failures, n_compared, src, src_set, ga, gb, res, inf, alm;
  integer     prs, pag, acc, q, edges, n_home, red_seen, i, a, b;
  reg  [1:0]  ab_q;

  servo_setup #(.HOLD_CYC(20), .WINDOW_CYC(50), .CONFIRM_CYC(5),
    .BLINK_CYC(4), .MOTOR_BASE(10000)) dut (.mclk(mclk), .resetn(resetn),
    .power_up(power_up), .config_exec(config_exec), .param_wr(param_wr),
    .param_id(param_id), .param_wdata(param_wdata),
    .sensor_gear_a(sga), .sensor_gear_b(sgb),
    .motor_step(motor_step), .motor_dir(motor_dir), .home_switch(sw),
    .nv_home_valid(nvh), .resolution(resolution), .gear_error_info(info),
    .gear_error_alarm(alarm), .preset_again(pa), .present_position(pos),
    .phase_a_pulse_output(ph_a), .phase_b_pulse_output(ph_b),
    .led_red(led_red), .led_green(led_green), .home_write(home_write),
    .home_position(hpos), .home_valid(home_valid), .backup_restore(b_rst),
    .backup_store(b_sto), .backup_reject(b_rej));
  switch_operator op (.mclk(mclk), .go(go), .hold_cyc(hold), .gap_cyc(gap),
    .again(again), .home_switch(sw), .busy(busy));

  // clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // watch phase edges, store pulses and red indicator
  always @(posedge mclk)
  begin
    if ({ph_a, ph_b} !== ab_q) edges = edges + 1;
    ab_q = {ph_a, ph_b};
    if (home_write === 1'b1) n_home = n_home + 1;
    if (led_red === 1'b1) red_seen = 1;
  end

  task finish_test;
    begin
      if (failures == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // model of the gear division and range check
  task recompute;
    integer r;
    begin
      r = src ? 1000 * gb / ga : 1000 * sgb / sga;
      if (r < 100 || r > 10000) inf = 1;
      else
      begin
        if (r != res && prs != 0) pag = 1;
        res = r;
        inf = 0;
      end
    end
  endtask
  task wr(input [15:0] id, input [31:0] d);
    begin
      @(posedge mclk);
      param_wr <= 1'b1;
      param_id <= id;
      param_wdata <= d;
      @(posedge mclk);
      param_wr <= 1'b0;
      if (id == `ID_ACCESS_KEY) akey = d;
      if (id == `ID_WRITE_KEY) wkey = d;
      if (id == `ID_MECH_SOURCE) src_set = d[0];
      if (id == `ID_PRESET_POS) prs = d;
      if (id == `ID_PRESET_POS) pag = 0;
      if (src_set && d != 0 && d < 32'h10000 && id == `ID_GEAR_A) ga = d;
      if (src_set && d != 0 && d < 32'h10000 && id == `ID_GEAR_B) gb = d;
      if (id == `ID_GEAR_A || id == `ID_GEAR_B) recompute;
    end
  endtask
  task cmd(input [15:0] id);
    reg ok;
    begin
      ok = akey == `ACCESS_KEY_CODE &&
        (id == `ID_RESTORE_CMD || wkey == `WRITE_KEY_CODE);
      wr(id, 32'h00000000);
      #1;
      `check(b_rst, ok && id == `ID_RESTORE_CMD, "restore")
      `check(b_sto, ok && id == `ID_STORE_CMD, "store")
      `check(b_rej, !ok, "reject")
    end
  endtask
  task pulse(input p, input c);
    begin
      @(posedge mclk);
      power_up <= p;
      config_exec <= c;
      @(posedge mclk);
      power_up <= 1'b0;
      config_exec <= 1'b0;
      if (inf) alm = 1;
      if (p) src = src_set;
      if (p) recompute;
    end
  endtask
  task gear_check;
    begin
      repeat (200) @(posedge mclk);
      `check(resolution, res[13:0], "resolution")
      `check(info, inf[0], "gear info")
      `check(alarm, alm[0], "gear alarm")
      `check(pa, pag[0], "preset again")
    end
  endtask
  task operate(input [7:0] h, input ag, input integer eh, input integer er);
    integer k;
    begin
      red_seen = 0;
      n_home = 0;
      @(posedge mclk);
      hold <= h;
      gap <= 8'h0A;
      again <= ag;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      k = 0;
      while (busy === 1'b1 && k < 400)
      begin
        @(posedge mclk);
        k = k + 1;
      end
      if (k == 400) failures = failures + 1;
      if (k == 400) finish_test;
      repeat (30) @(posedge mclk);
      `check(n_home, eh, "home store count")
      `check(red_seen, er, "blink seen")
      `check(led_red, 1'b0, "red after sequence")
      `check(led_green, 1'b1, "green after sequence")
    end
  endtask

  initial
  begin
    {resetn, power_up, config_exec, param_wr, motor_step, go} = 6'h00;
    {motor_dir, nvh} = 2'b00;
    sga = 16'h000A;
    sgb = 16'h000C;
    {param_id, param_wdata, hold, gap, again} = 65'h0;
    {akey, wkey} = 64'h0;
    {failures, n_compared, src, src_set, prs, pag, inf, alm} = 0;
    {acc, q} = 0;
    ga = 1;
    gb = 1;
    res = 1000;
    void'($urandom(45733));
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    `check(resolution, 14'h03E8, "reset resolution")
    `check(home_valid, 1'b0, "home unset")
    cmd(`ID_RESTORE_CMD);
    wr(`ID_ACCESS_KEY, `ACCESS_KEY_CODE);
    cmd(`ID_RESTORE_CMD);
    cmd(`ID_STORE_CMD);
    wr(`ID_WRITE_KEY, `WRITE_KEY_CODE);
    cmd(`ID_STORE_CMD);
    wr(`ID_ACCESS_KEY, 32'h00000000);
    cmd(`ID_STORE_CMD);
    wr(`ID_GEAR_B, 32'h00000005);
    gear_check;
    sgb <= 16'h0024;
    pulse(1'b1, 1'b0);
    gear_check;
    wr(`ID_MECH_SOURCE, 32'h00000001);
    pulse(1'b1, 1'b0);
    wr(`ID_GEAR_A, 32'h0000000A);
    wr(`ID_GEAR_B, 32'h00000024);
    gear_check;
    wr(`ID_GEAR_A, 32'h00000000);
    gear_check;
    wr(`ID_PRESET_POS, 32'h00000005);
    for (i = 0; i < 6; i = i + 1)
    begin
      a = 1 + $urandom % 20;
      b = 1 + $urandom % 300;
      wr(`ID_GEAR_A, a);
      repeat (100) @(posedge mclk);
      wr(`ID_GEAR_B, b);
      gear_check;
    end
    wr(`ID_GEAR_A, 32'h00000001);
    wr(`ID_GEAR_B, 32'h0000000B);
    gear_check;
    pulse(1'b0, 1'b1);
    gear_check;
    edges = 0;
    for (i = 0; i < 40; i = i + 1)
    begin
      @(posedge mclk);
      motor_step <= 1'b1;
      @(posedge mclk);
      motor_step <= 1'b0;
      acc = acc + res;
      while (acc >= 10000) {acc, q} = {acc - 10000, q + 1};
    end
    repeat (5) @(posedge mclk);
    `check(edges, q, "phase edge count")
    `check(pos, q, "position forward")
    // reverse motion walks the phases and position back
    edges = 0;
    b = 0;
    for (i = 0; i < 20; i = i + 1)
    begin
      @(posedge mclk);
      motor_step <= 1'b1;
      motor_dir <= 1'b1;
      @(posedge mclk);
      motor_step <= 1'b0;
      if (acc < res)
      begin
        acc = acc + 10000 - res;
        q = q - 1;
        b = b + 1;
      end
      else
        acc = acc - res;
    end
    repeat (5) @(posedge mclk);
    `check(edges, b, "reverse edge count")
    `check(pos, q, "position reverse")
    operate(8'h0A, 1'b0, 0, 0);
    operate(8'h50, 1'b0, 0, 1);
    operate(8'h1E, 1'b1, 1, 1);
    `check(home_valid, 1'b1, "home stored")
    `check(hpos, 24'h000014, "home position")
    // mid-run reset: home flag reloads from the stored copy
    nvh <= 1'b1;
    resetn <= 1'b0;
    repeat (3) @(posedge mclk);
    `check(home_valid, 1'b0, "home cleared in reset")
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    `check(home_valid, 1'b1, "home reloaded")
    `check(alarm, 1'b0, "alarm after reset")
    `check(resolution, 14'h03E8, "resolution after reset")
    finish_test;
  end
endmodule // tb
